// *** rtl/chpd_pkg.sv ***
// constants and types for the channel plan decoder
package chpd_pkg;
  // ==========================================================================
  // plan table encoding
  localparam int          SEL_W        = 4;
  localparam int          CH_W         = 3;
  localparam int          MASK_W       = 7;
  localparam logic [3:0]  POS_CUSTOM   = 4'h0;
  localparam logic [3:0]  POS_RSV_E    = 4'he;
  localparam logic [3:0]  POS_RSV_F    = 4'hf;
  localparam logic [3:0]  POS_SINGLE_LAST = 4'h6;
  localparam logic [2:0]  CH_NONE      = 3'h0;
  localparam logic [6:0]  MASK_NONE    = 7'h00;
  // mask bit n-1 stands for channel n
  localparam logic [2:0]  CH1 = 3'h1;
  localparam logic [2:0]  CH2 = 3'h2;
  localparam logic [2:0]  CH3 = 3'h3;
  localparam logic [2:0]  CH4 = 3'h4;
  localparam logic [2:0]  CH5 = 3'h5;
  localparam logic [2:0]  CH7 = 3'h7;
  localparam logic [6:0]  M_7 = 7'h09;  // ch 1,4
  localparam logic [6:0]  M_8 = 7'h50;  // ch 5,7
  localparam logic [6:0]  M_9 = 7'h24;  // ch 3,6
  localparam logic [6:0]  M_A = 7'h11;  // ch 1,5
  localparam logic [6:0]  M_B = 7'h22;  // ch 2,6
  localparam logic [6:0]  M_C = 7'h28;  // ch 4,6
  localparam logic [6:0]  M_D = 7'h45;  // ch 1,3,7
  // ==========================================================================
  // timing
  localparam int          CLK_MHZ      = 100;
  localparam int          DWELL_MS     = 500;
  localparam int          DWELL_CYC    = DWELL_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W        = 26;
  localparam int          SEQ_W        = 5;
  typedef enum logic [1:0] {ST_IDLE, ST_SIGNAL, ST_OPERATE} chpd_state_type;
endpackage : chpd_pkg

// *** rtl/chpd_sync.sv ***
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module chpd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // sync reset, active low
  input  wire logic [W-1:0] d,      // asynchronous input
  output logic      [W-1:0] q       // synchronised output
);
  logic [W-1:0] meta_q;
  // ==========================================================================
  // per-bit stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : chpd_sync
`default_nettype wire

// *** rtl/chpd_decoder.sv ***
// channel plan decoder: latches the rotary selector after reset
`timescale 1ns/1ps
`default_nettype none
// Contract
// - read a four-bit, sixteen-position selector as the plan choice.
// - selector changes take effect only through a reset.
// - positions 1-6 signal on channel 7, operate on the position's channel.
// - positions 7-9 signal on 2; operate 1+4, 5+7, 3+6.
// - A: 3 / 1+5; B: 4 / 2+6; C: 2 / 4+6; D: 5 / 1+3+7.
// - positions E and F are reserved and select no plan.
// - position zero selects the configured custom group with channel search.
// - call setup on signalling channel, dwell about 500 ms, then operate.
// - first chained unit sources timing; later units follow it.
// - linked transmitters switch tx/rx on the shared timing instant.
// - nonzero positions use the fixed table; only zero allows configured set.
module chpd_decoder #(
  parameter int DWELL_CYCLES = chpd_pkg::DWELL_CYC
) (
  input  wire logic       clk,            // 100 MHz system clock
  input  wire logic       rst_n,          // sync reset, active low
  input  wire logic [3:0] sel_pin,        // rotary selector, asynchronous
  input  wire logic       call_start,     // pulse: begin call setup
  input  wire logic       call_end,       // pulse: tear down call
  input  wire logic       chain_first,    // strap: this unit heads the sync chain
  input  wire logic       sync_in,        // timing reference from upstream unit
  input  wire logic       local_tick,     // own tx/rx frame tick, same clock
  output logic            sync_out,       // timing reference to downstream unit
  output logic            txrx_switch,    // pulse: switch tx/rx now
  output logic [2:0]      sig_chan,       // signalling channel index
  output logic [6:0]      op_mask,        // operating channel mask
  output logic            custom_grp,     // custom searched group active
  output logic            reserved_pos,   // reserved selector position
  output logic            plan_valid,     // plan latched after reset
  output logic            on_signal,      // dwelling on signalling channel
  output logic            on_operate,     // moved to operating channel
  output logic [2:0]      tune_chan       // channel currently tuned (0 = none, idle)
);
  // ==========================================================================
  // selector synchronisation
  logic [3:0] sel_s;
  logic       sync_s;
  chpd_sync #(.W(5)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sync_in, sel_pin}),
    .q     ({sync_s, sel_s})
  );

  // ==========================================================================
  // capture once after reset release, after the synchroniser has settled
  logic [1:0] settle_q;
  logic       cap_q;
  logic [3:0] pos_q;
  wire        take = (settle_q == 2'h2) && !cap_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'h2) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // later selector moves are ignored until the next reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_q <= 1'b0;
      pos_q <= chpd_pkg::POS_CUSTOM;
    end else if (take) begin
      cap_q <= 1'b1;
      pos_q <= sel_s;
    end
  end

  // ==========================================================================
  // plan table
  logic [2:0] sig_d;
  logic [6:0] mask_d;
  wire        is_custom = (pos_q == chpd_pkg::POS_CUSTOM);
  wire        is_rsv    = (pos_q == chpd_pkg::POS_RSV_E) ||
                          (pos_q == chpd_pkg::POS_RSV_F);
  wire        is_single = !is_custom && (pos_q <= chpd_pkg::POS_SINGLE_LAST);
  wire [6:0]  single_mask = 7'(7'h01 << (pos_q[2:0] - 3'h1));

  always_comb begin
    sig_d  = chpd_pkg::CH_NONE;
    mask_d = chpd_pkg::MASK_NONE;
    case (pos_q)
      4'h7: begin sig_d = chpd_pkg::CH2; mask_d = chpd_pkg::M_7; end
      4'h8: begin sig_d = chpd_pkg::CH2; mask_d = chpd_pkg::M_8; end
      4'h9: begin sig_d = chpd_pkg::CH2; mask_d = chpd_pkg::M_9; end
      4'ha: begin sig_d = chpd_pkg::CH3; mask_d = chpd_pkg::M_A; end
      4'hb: begin sig_d = chpd_pkg::CH4; mask_d = chpd_pkg::M_B; end
      4'hc: begin sig_d = chpd_pkg::CH2; mask_d = chpd_pkg::M_C; end
      4'hd: begin sig_d = chpd_pkg::CH5; mask_d = chpd_pkg::M_D; end
      default: begin
        if (is_single) begin
          sig_d  = chpd_pkg::CH7;
          mask_d = single_mask;
        end
      end
    endcase
  end

  // fixed table for nonzero positions, custom group only at zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sig_chan     <= chpd_pkg::CH_NONE;
      op_mask      <= chpd_pkg::MASK_NONE;
      custom_grp   <= 1'b0;
      reserved_pos <= 1'b0;
      plan_valid   <= 1'b0;
    end else begin
      sig_chan     <= sig_d;
      op_mask      <= mask_d;
      custom_grp   <= cap_q && is_custom;
      reserved_pos <= cap_q && is_rsv;
      plan_valid   <= cap_q && !is_rsv;
    end
  end

  // ==========================================================================
  // call setup: dwell on signalling channel, then first operating channel
  chpd_pkg::chpd_state_type st_q, st_d;
  logic [chpd_pkg::CNT_W-1:0] dwell_q;
  logic [2:0]                 first_op;
  wire  dwell_done = (dwell_q == chpd_pkg::CNT_W'(DWELL_CYCLES - 1));
  wire  can_call   = plan_valid && !custom_grp;

  always_comb begin
    first_op = chpd_pkg::CH_NONE;
    for (int i = chpd_pkg::MASK_W - 1; i >= 0; i--) begin
      if (op_mask[i]) first_op = 3'(i + 1);
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      chpd_pkg::ST_IDLE:    if (call_start && can_call) st_d = chpd_pkg::ST_SIGNAL;
      chpd_pkg::ST_SIGNAL:  if (call_end) st_d = chpd_pkg::ST_IDLE;
                            else if (dwell_done) st_d = chpd_pkg::ST_OPERATE;
      chpd_pkg::ST_OPERATE: if (call_end) st_d = chpd_pkg::ST_IDLE;
      default:              st_d = chpd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= chpd_pkg::ST_IDLE;
      dwell_q <= '0;
    end else begin
      st_q    <= st_d;
      dwell_q <= (st_q == chpd_pkg::ST_SIGNAL && !dwell_done) ?
                 dwell_q + 1'b1 : '0;
    end
  end

  assign on_signal  = (st_q == chpd_pkg::ST_SIGNAL);
  assign on_operate = (st_q == chpd_pkg::ST_OPERATE);

  always_ff @(posedge clk) begin
    if (!rst_n) tune_chan <= chpd_pkg::CH_NONE;
    else        tune_chan <= (st_d == chpd_pkg::ST_SIGNAL) ? sig_chan :
                             (st_d == chpd_pkg::ST_OPERATE) ? first_op :
                             chpd_pkg::CH_NONE;
  end

  // ==========================================================================
  // co-location timing: head of chain sources, others follow upstream
  logic sync_prev_q;
  wire  ref_tick = chain_first ? local_tick : (sync_s && !sync_prev_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_prev_q <= 1'b0;
      sync_out    <= 1'b0;
      txrx_switch <= 1'b0;
    end else begin
      sync_prev_q <= sync_s;
      sync_out    <= chain_first ? local_tick : sync_s;
      txrx_switch <= ref_tick;
    end
  end

  // ==========================================================================
  // checks
  property p_sel_hold;
    @(posedge clk) disable iff (!rst_n) cap_q |=> $stable(pos_q);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("plan changed w/o reset");

  property p_rsv;
    @(posedge clk) disable iff (!rst_n)
      (cap_q && is_rsv) |=> (reserved_pos && op_mask == 7'h00 && !plan_valid);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved position gave a plan");

  property p_single;
    @(posedge clk) disable iff (!rst_n)
      is_single |=> (sig_chan == 3'h7 && $countones(op_mask) == 1);
  endproperty
  a_single: assert property (p_single) else $error("single plan wrong");

  property p_pos7;
    @(posedge clk) disable iff (!rst_n)
      (pos_q == 4'h7) |=> (sig_chan == 3'h2 && op_mask == 7'h09);
  endproperty
  a_pos7: assert property (p_pos7) else $error("position 7 plan wrong");

  property p_posd;
    @(posedge clk) disable iff (!rst_n)
      (pos_q == 4'hd) |=> (sig_chan == 3'h5 && op_mask == 7'h45);
  endproperty
  a_posd: assert property (p_posd) else $error("position d plan wrong");

  property p_custom;
    @(posedge clk) disable iff (!rst_n)
      (cap_q && pos_q == 4'h0) |=> (custom_grp && op_mask == 7'h00);
  endproperty
  a_custom: assert property (p_custom) else $error("custom group not flagged");

  sequence s_enter_signal;
    !on_signal ##1 on_signal;
  endsequence
  property p_dwell;
    @(posedge clk) disable iff (!rst_n)
      s_enter_signal |-> (on_signal && tune_chan == sig_chan)[*8];
  endproperty
  a_dwell: assert property (p_dwell) else $error("left signal channel early");

  property p_switch;
    @(posedge clk) disable iff (!rst_n)
      (chain_first ? local_tick : $rose(sync_s)) |=> txrx_switch;
  endproperty
  a_switch: assert property (p_switch) else $error("tx/rx switch missed");

  property p_src;
    @(posedge clk) disable iff (!rst_n) chain_first |=> sync_out == $past(local_tick);
  endproperty
  a_src: assert property (p_src) else $error("head unit not sourcing");
endmodule : chpd_decoder
`default_nettype wire

// *** tb/chpd_switch_model.sv ***
// far-side model: rotary selector and upstream timing unit
`timescale 1ns/1ps
`default_nettype none
module chpd_switch_model (
  input  wire logic       clk,      // system clock
  input  wire logic [3:0] pos,      // position the bench turns the knob to
  input  wire logic       fire,     // request one upstream reference tick
  output logic      [3:0] sel_pin,  // selector contacts
  output logic            sync_in   // timing reference from upstream unit
);
  // start value given at declaration: always_ff must stay the only process writing hold_q
  logic [1:0] hold_q = 2'h0;
  // ==========================================================================
  // selector: a mechanical switch always shows its position, all 16 codes
  assign sel_pin = pos;
  // ==========================================================================
  // upstream head of chain: a wide pulse so the 2-flop sync cannot miss it
  always_ff @(posedge clk) begin
    hold_q <= fire ? 2'h3 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
  end
  assign sync_in = (hold_q != 2'h0);
endmodule : chpd_switch_model
`default_nettype wire

// *** tb/chpd_decoder_tb.sv ***
// self-checking bench for the channel plan decoder
`timescale 1ns/1ps
`default_nettype none
module chpd_decoder_tb;
  localparam int DWELL = 20;
  typedef struct {logic [3:0] pos; logic [2:0] sig; logic [6:0] mask; logic cust; logic rsv;}
    chpd_row_type;
  logic clk, rst_n, call_start, call_end, chain_first, local_tick, fire;
  logic sync_in, sync_out, txrx_switch, custom_grp, reserved_pos;
  logic plan_valid, on_signal, on_operate;
  logic [3:0] pos, sel_pin;
  logic [2:0] sig_chan, tune_chan;
  logic [6:0] op_mask;
  int   fails, comparisons;
  chpd_row_type rows [15] = '{
    '{4'h1, 3'h7, 7'h01, 1'b0, 1'b0}, '{4'h2, 3'h7, 7'h02, 1'b0, 1'b0},
    '{4'h3, 3'h7, 7'h04, 1'b0, 1'b0}, '{4'h4, 3'h7, 7'h08, 1'b0, 1'b0},
    '{4'h5, 3'h7, 7'h10, 1'b0, 1'b0}, '{4'h6, 3'h7, 7'h20, 1'b0, 1'b0},
    '{4'h7, 3'h2, 7'h09, 1'b0, 1'b0}, '{4'h8, 3'h2, 7'h50, 1'b0, 1'b0},
    '{4'h9, 3'h2, 7'h24, 1'b0, 1'b0}, '{4'ha, 3'h3, 7'h11, 1'b0, 1'b0},
    '{4'hb, 3'h4, 7'h22, 1'b0, 1'b0}, '{4'hc, 3'h2, 7'h28, 1'b0, 1'b0},
    '{4'hd, 3'h5, 7'h45, 1'b0, 1'b0}, '{4'he, 3'h0, 7'h00, 1'b0, 1'b1},
    '{4'hf, 3'h0, 7'h00, 1'b0, 1'b1}};
  chpd_decoder #(.DWELL_CYCLES(DWELL)) u_dut (
    .clk(clk), .rst_n(rst_n), .sel_pin(sel_pin), .call_start(call_start),
    .call_end(call_end), .chain_first(chain_first), .sync_in(sync_in),
    .local_tick(local_tick), .sync_out(sync_out), .txrx_switch(txrx_switch),
    .sig_chan(sig_chan), .op_mask(op_mask), .custom_grp(custom_grp),
    .reserved_pos(reserved_pos), .plan_valid(plan_valid), .on_signal(on_signal),
    .on_operate(on_operate), .tune_chan(tune_chan));
  chpd_switch_model u_far (
    .clk(clk), .pos(pos), .fire(fire), .sel_pin(sel_pin), .sync_in(sync_in));
  // ==========================================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // plan is sampled only around reset, so every position costs one reset
  task automatic do_reset;
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(6);
  endtask : do_reset
  task automatic pulse_call;
    call_start = 1'b1;
    step(1);
    call_start = 1'b0;
  endtask : pulse_call
  initial begin
    #100000;
    fails++;
    final_report();
  end
  // ==========================================================================
  // main sequence
  initial begin
    {rst_n, call_start, call_end, chain_first, local_tick, fire} = 6'h00;
    pos = 4'h0;
    fails = 0;
    comparisons = 0;
    step(2);
    check("reset sig_chan", {4'h0, sig_chan}, 7'h00);
    check("reset plan_valid", {6'h00, plan_valid}, 7'h00);
    foreach (rows[i]) begin
      pos = rows[i].pos;
      do_reset();
      check("sig_chan", {4'h0, sig_chan}, {4'h0, rows[i].sig});
      check("op_mask", op_mask, rows[i].mask);
      check("custom_grp", {6'h00, custom_grp}, {6'h00, rows[i].cust});
      check("reserved_pos", {6'h00, reserved_pos}, {6'h00, rows[i].rsv});
      check("plan_valid", {6'h00, plan_valid}, {6'h00, ~rows[i].rsv});
    end
    // reserved position refuses a call
    pulse_call();
    step(1);
    check("rsv on_signal", {6'h00, on_signal}, 7'h00);
    // position zero: custom group, no fixed call
    pos = 4'h0;
    do_reset();
    check("custom flag", {6'h00, custom_grp}, 7'h01);
    check("custom rsv", {6'h00, reserved_pos}, 7'h00);
    pulse_call();
    step(1);
    check("custom on_signal", {6'h00, on_signal}, 7'h00);
    // knob turned with no reset: plan must not move
    pos = 4'hd;
    do_reset();
    pos = 4'h8;
    step(10);
    check("held sig", {4'h0, sig_chan}, 7'h05);
    check("held mask", op_mask, 7'h45);
    // call on position d: dwell on channel 5, then operate on lowest, channel 1
    pulse_call();
    check("dwell on_signal", {6'h00, on_signal}, 7'h01);
    check("dwell tune", {4'h0, tune_chan}, 7'h05);
    // last dwell cycle, then the move to the operating channel on the very next edge
    step(DWELL - 1);
    check("still dwell", {6'h00, on_signal}, 7'h01);
    check("dwell end tune", {4'h0, tune_chan}, 7'h05);
    step(1);
    check("operate", {6'h00, on_operate}, 7'h01);
    check("operate tune", {4'h0, tune_chan}, 7'h01);
    call_end = 1'b1;
    step(1);
    call_end = 1'b0;
    check("idle tune", {4'h0, tune_chan}, 7'h00);
    // head of chain: own tick drives the switch instant and the downstream ref
    chain_first = 1'b1;
    local_tick = 1'b1;
    step(1);
    local_tick = 1'b0;
    check("head switch", {6'h00, txrx_switch}, 7'h01);
    check("head sync_out", {6'h00, sync_out}, 7'h01);
    step(1);
    check("head pulse", {6'h00, txrx_switch}, 7'h00);
    // follower: own tick ignored, upstream reference used
    chain_first = 1'b0;
    local_tick = 1'b1;
    step(1);
    local_tick = 1'b0;
    check("follow local", {6'h00, txrx_switch}, 7'h00);
    step(3);
    fire = 1'b1;
    step(1);
    fire = 1'b0;
    // two sync flops, then one registered edge: switch lands on the third edge
    step(2);
    check("follow early", {6'h00, txrx_switch}, 7'h00);
    step(1);
    check("follow switch", {6'h00, txrx_switch}, 7'h01);
    check("follow sync_out", {6'h00, sync_out}, 7'h01);
    step(1);
    check("follow pulse", {6'h00, txrx_switch}, 7'h00);
    final_report();
  end
endmodule : chpd_decoder_tb
`default_nettype wire
